/* File: design/mrmc_core.sv */
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "mrmc_defs.svh"
module mrmc_core
    import mrmc_pkg::*;
#(
    parameter int MAX_COL = 64
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        midi_valid,
    input  wire logic [7:0]  midi_byte,
    output logic             evt_valid,
    output mrmc_event_t      evt_kind,
    output logic [1:0]       evt_row,
    output logic [5:0]       evt_index,
    output logic [6:0]       evt_value,
    output logic             disp_req,
    output logic             disp_full,
    output logic [1:0]       block_row,
    output logic [5:0]       block_col
);
    // ==========================================================
    // apb slave state
    logic [6:0]  ctrl_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    // mixer state
    logic        dim_ff, mono_ff, talk_ff, spkb_ff, trim_ff, mmute_ff, msolo_ff;
    logic [2:0]  cue_ff;
    logic [5:0]  submix_ff;
    logic [6:0]  main_vol_ff;
    logic [3:0]  reverb_ff, echo_ff;
    logic [2:0]  snap_ff;
    logic [1:0]  row_ff;
    logic [5:0]  col_ff;
    logic        evt_valid_ff;
    mrmc_event_t evt_kind_ff;
    logic [1:0]  evt_row_ff;
    logic [5:0]  evt_index_ff;
    logic [6:0]  evt_value_ff;
    logic        disp_req_ff, disp_full_ff;
    // parser state
    logic        rs_valid_ff, have_d1_ff;
    logic [3:0]  rs_type_ff, rs_chan_ff;
    logic [6:0]  d1_ff;

    // ==========================================================
    // helpers
    function automatic logic [1:0] row_of(input logic [3:0] ch);
        row_of = ch[3:2];
    endfunction : row_of

    function automatic logic [5:0] col_step(input logic [5:0] col, input logic [6:0] step,
                                            input logic right, input logic [6:0] width);
        logic [7:0] lim;
        logic [7:0] sum;
        lim = 8'(MAX_COL) - {1'b0, width};
        sum = {2'b00, col} + {1'b0, step};
        if (right) begin
            col_step = (sum > lim) ? lim[5:0] : sum[5:0];
        end else begin
            col_step = ({2'b00, col} < {1'b0, step}) ? 6'h00 : 6'(col - step[5:0]);
        end
    endfunction : col_step

    // ==========================================================
    // apb register access, one wait state
    wire acc     = psel && penable;
    wire wr_done = acc && pwrite && pready_ff;
    wire [31:0] state_word = {25'h0, msolo_ff, mmute_ff, trim_ff, spkb_ff, talk_ff,
                              mono_ff, dim_ff};
    wire [31:0] mix_word   = {2'h0, main_vol_ff, col_ff, row_ff, cue_ff, 5'h00, 1'b1,
                              submix_ff};         // bit 6 submix view always
    wire [31:0] pre_word   = {21'h0, snap_ff, echo_ff, reverb_ff};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end else if (acc && !pready_ff) begin
            pready_ff  <= 1'b1;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
            if (paddr == `MRMC_ADDR_CTRL) begin
                prdata_ff <= {25'h0, ctrl_ff};
            end else if (paddr == `MRMC_ADDR_STATE) begin
                prdata_ff <= state_word;
            end else if (paddr == `MRMC_ADDR_MIX) begin
                prdata_ff <= mix_word;
            end else if (paddr == `MRMC_ADDR_PRESET) begin
                prdata_ff <= pre_word;
            end else begin
                pslverr_ff <= 1'b1;
            end
        end else begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    // control register; read-only words ignore writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `MRMC_CTRL_RESET;
        end else if (wr_done && paddr == `MRMC_ADDR_CTRL) begin
            ctrl_ff <= pwdata[6:0];
        end
    end

    wire remote_control_enable      = ctrl_ff[`MRMC_BIT_REMOTE_EN];
    wire surface_en                 = ctrl_ff[`MRMC_BIT_SURFACE_EN];
    wire full_display_feedback      = ctrl_ff[`MRMC_BIT_FULL_DISP];
    wire background_control_disable = ctrl_ff[`MRMC_BIT_BG_DIS];
    wire app_focus                  = ctrl_ff[`MRMC_BIT_FOCUS];
    wire extender_en                = ctrl_ff[`MRMC_BIT_EXTENDER];
    wire standalone                 = ctrl_ff[`MRMC_BIT_STANDALONE];

    // ==========================================================
    // byte parser with running status; realtime bytes pass through
    wire is_status = midi_valid && midi_byte[7];
    wire two_data  = (rs_type_ff == `MRMC_ST_NOTE_OFF) || (rs_type_ff == `MRMC_ST_NOTE_ON) ||
                     (rs_type_ff == `MRMC_ST_CTRL) || (rs_type_ff == `MRMC_ST_BEND);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rs_valid_ff <= 1'b0;
            have_d1_ff  <= 1'b0;
            rs_type_ff  <= 4'h0;
            rs_chan_ff  <= 4'h0;
            d1_ff       <= 7'h00;
        end else if (is_status) begin
            if (midi_byte < 8'hf0) begin
                rs_valid_ff <= 1'b1;
                rs_type_ff  <= midi_byte[7:4];
                rs_chan_ff  <= midi_byte[3:0];    // zero-based
                have_d1_ff  <= 1'b0;
            end else if (midi_byte < 8'hf8) begin
                rs_valid_ff <= 1'b0;              // system common drops running status
                have_d1_ff  <= 1'b0;
            end
        end else if (midi_valid && rs_valid_ff && two_data) begin
            have_d1_ff <= !have_d1_ff;
            if (!have_d1_ff) begin
                d1_ff <= midi_byte[6:0];
            end
        end
    end

    // a complete message is seen on its last byte
    wire msg_done = midi_valid && !midi_byte[7] && rs_valid_ff && two_data && have_d1_ff;
    wire live     = !(background_control_disable && !app_focus);
    wire take     = msg_done && live;
    wire [6:0] d2 = midi_byte[6:0];
    wire ch0      = (rs_chan_ff == 4'h0);
    // note buttons are part of the surface protocol
    wire press    = take && ch0 && surface_en && (rs_type_ff == `MRMC_ST_NOTE_ON) &&
                    (d2 != 7'h00);
    wire is_cc    = take && (rs_type_ff == `MRMC_ST_CTRL);
    wire cc_fader = is_cc && (rs_chan_ff <= `MRMC_CH_LAST_FADER) &&
                    (d1_ff >= `MRMC_CC_FADER_LO) && (d1_ff <= `MRMC_CC_FADER_HI) &&
                    !(standalone && row_of(rs_chan_ff) == 2'd1);
    wire cc_trim  = is_cc && (rs_chan_ff == `MRMC_CH_MIXSEL) && (d1_ff == `MRMC_CC_FADER_LO);
    wire cc_mix   = is_cc && (rs_chan_ff == `MRMC_CH_MIXSEL) && (d1_ff >= `MRMC_CC_MIX_LO) &&
                    (7'(d1_ff - `MRMC_CC_MIX_LO) < 7'(MAX_COL));
    wire rec_hit  = press && (d1_ff <= `MRMC_N_REC_HI);
    wire [6:0] rec_col = 7'(col_ff) + d1_ff;
    wire sel_mix  = cc_mix || (rec_hit && rec_col < 7'(MAX_COL));
    wire [5:0] mix_tgt = cc_mix ? 6'(d1_ff - `MRMC_CC_MIX_LO) : rec_col[5:0];
    wire [6:0] blk_w   = extender_en ? 7'(2 * `MRMC_BLOCK_W) : `MRMC_BLOCK_W;

    // ==========================================================
    // button toggles and selections
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dim_ff   <= 1'b0;
            mono_ff  <= 1'b0;
            talk_ff  <= 1'b0;
            spkb_ff  <= 1'b0;
            mmute_ff <= 1'b0;
            msolo_ff <= 1'b0;
            cue_ff   <= 3'h0;
        end else if (press) begin
            if (d1_ff == `MRMC_N_DIM) dim_ff <= !dim_ff;
            if (d1_ff == `MRMC_N_MONO) mono_ff <= !mono_ff;
            if (d1_ff == `MRMC_N_TALK) talk_ff <= !talk_ff;
            if (d1_ff == `MRMC_N_SPKB) spkb_ff <= !spkb_ff;
            if (d1_ff == `MRMC_N_MMUTE) mmute_ff <= !mmute_ff;
            if (d1_ff == `MRMC_N_MSOLO) msolo_ff <= !msolo_ff;
            if (d1_ff >= `MRMC_N_CUE_LO && d1_ff <= `MRMC_N_CUE_HI) begin
                cue_ff <= 3'(d1_ff - `MRMC_N_CUE_LO);
            end
        end
    end

    // trim gains: note or channel 13 toggles, any mix selection clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_ff   <= 1'b0;
            submix_ff <= 6'h00;
        end else if (sel_mix) begin
            trim_ff   <= 1'b0;
            submix_ff <= mix_tgt;
        end else if (cc_trim || (press && d1_ff == `MRMC_N_TRIM)) begin
            trim_ff   <= !trim_ff;
        end
    end

    // ==========================================================
    // block navigation; stand-alone hops over the middle row
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_ff <= 2'd0;
            col_ff <= 6'h00;
        end else if (press) begin
            if (d1_ff == `MRMC_N_NAV_L1) col_ff <= col_step(col_ff, 7'd1, 1'b0, blk_w);
            if (d1_ff == `MRMC_N_NAV_R1) col_ff <= col_step(col_ff, 7'd1, 1'b1, blk_w);
            if (d1_ff == `MRMC_N_NAV_L8) col_ff <= col_step(col_ff, `MRMC_BLOCK_W, 1'b0, blk_w);
            if (d1_ff == `MRMC_N_NAV_R8) col_ff <= col_step(col_ff, `MRMC_BLOCK_W, 1'b1, blk_w);
            if (d1_ff == `MRMC_N_NAV_UP && row_ff != 2'd0) begin
                row_ff <= (standalone && row_ff == 2'd2) ? 2'd0 : 2'(row_ff - 2'd1);
            end
            if (d1_ff == `MRMC_N_NAV_DN && row_ff != 2'd2) begin
                row_ff <= (standalone && row_ff == 2'd0) ? 2'd2 : 2'(row_ff + 2'd1);
            end
        end
    end

    wire nav_hit = press && (d1_ff >= `MRMC_N_NAV_L1) && (d1_ff <= `MRMC_N_NAV_DN);

    // display refresh after any move or destination change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_req_ff  <= 1'b0;
            disp_full_ff <= 1'b0;
        end else begin
            disp_req_ff  <= nav_hit || sel_mix;
            disp_full_ff <= full_display_feedback && !standalone;
        end
    end

    // ==========================================================
    // one-cycle mixer event out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_valid_ff <= 1'b0;
            evt_kind_ff  <= mrmc_ev_none;
            evt_row_ff   <= 2'd0;
            evt_index_ff <= 6'h00;
            evt_value_ff <= 7'h00;
            main_vol_ff  <= `MRMC_UNITY;
            reverb_ff    <= 4'h0;
            echo_ff      <= 4'h0;
            snap_ff      <= 3'h0;
        end else begin
            evt_valid_ff <= 1'b0;                 // unmatched messages
            evt_value_ff <= d2;
            evt_row_ff   <= row_of(rs_chan_ff);
            evt_index_ff <= {rs_chan_ff[1:0], 4'(d1_ff - `MRMC_CC_FADER_LO)};
            if (cc_fader) begin
                evt_valid_ff <= 1'b1;
                evt_kind_ff  <= mrmc_ev_fader;
            end else if ((is_cc && ch0 && d1_ff == `MRMC_CC_VOLUME) ||
                         (take && rs_type_ff == `MRMC_ST_BEND &&
                          rs_chan_ff == `MRMC_CH_MASTER)) begin
                evt_valid_ff <= 1'b1;
                evt_kind_ff  <= mrmc_ev_main_vol;
                evt_row_ff   <= 2'd2;
                main_vol_ff  <= d2;
            end else if (is_cc && d1_ff == `MRMC_CC_GAIN && remote_control_enable) begin
                evt_valid_ff <= 1'b1;
                evt_kind_ff  <= mrmc_ev_input_gain;
                evt_index_ff <= {2'b00, rs_chan_ff};
                evt_value_ff <= (d2 > `MRMC_GAIN_MAX) ? `MRMC_GAIN_MAX : d2;
            end else if (is_cc && d1_ff == `MRMC_CC_PRESET && d2 >= 7'h01 &&
                         d2 <= `MRMC_PRESET_MAX &&
                         (rs_chan_ff == `MRMC_CH_REVERB || rs_chan_ff == `MRMC_CH_ECHO)) begin
                evt_valid_ff <= 1'b1;
                if (rs_chan_ff == `MRMC_CH_REVERB) begin
                    evt_kind_ff <= mrmc_ev_reverb;
                    reverb_ff   <= 4'(d2 - 7'h01);
                end else begin
                    evt_kind_ff <= mrmc_ev_echo;
                    echo_ff     <= 4'(d2 - 7'h01);
                end
            end else if (press && d1_ff >= `MRMC_N_SNAP_LO && d1_ff <= `MRMC_N_SNAP_HI) begin
                evt_valid_ff <= 1'b1;
                evt_kind_ff  <= mrmc_ev_snapshot;
                evt_index_ff <= 6'(d1_ff - `MRMC_N_SNAP_LO);
                snap_ff      <= 3'(d1_ff - `MRMC_N_SNAP_LO);
            end else if (press && d1_ff == `MRMC_N_RECALL) begin
                evt_valid_ff <= 1'b1;
                evt_kind_ff  <= mrmc_ev_recall;
            end
        end
    end

    assign prdata    = prdata_ff;
    assign pready    = pready_ff;
    assign pslverr   = pslverr_ff;
    assign evt_valid = evt_valid_ff;
    assign evt_kind  = evt_kind_ff;
    assign evt_row   = evt_row_ff;
    assign evt_index = evt_index_ff;
    assign evt_value = evt_value_ff;
    assign disp_req  = disp_req_ff;
    assign disp_full = disp_full_ff;
    assign block_row = row_ff;
    assign block_col = col_ff;

    // ==========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_dim_toggle: assert property (press && d1_ff == `MRMC_N_DIM |=> dim_ff != $past(dim_ff))
        else $error("dim did not toggle");
    a_cue_select: assert property (press && d1_ff == `MRMC_N_CUE_LO + 7'd2 |=> cue_ff == 3'd2)
        else $error("cue source wrong");
    a_snap_index: assert property (press && d1_ff == `MRMC_N_SNAP_HI |=> evt_valid && evt_index == 6'd7)
        else $error("snapshot index wrong");
    a_surface_off: assert property (take && !surface_en && rs_type_ff == `MRMC_ST_NOTE_ON
        |=> $stable({dim_ff, mono_ff, talk_ff, spkb_ff, mmute_ff, msolo_ff, cue_ff})
            && !evt_valid)
        else $error("note acted with surface off");
    a_fader_addr: assert property (cc_fader && rs_chan_ff == 4'h9 && d1_ff == 7'h75
        |=> evt_kind == mrmc_ev_fader && evt_row == 2'd2 && evt_index == 6'h1f)
        else $error("fader address wrong");
    a_trim_clear: assert property (trim_ff && sel_mix |=> !trim_ff)
        else $error("mix select kept trim");
    a_gain_cap: assert property (evt_valid && evt_kind == mrmc_ev_input_gain
        |-> evt_value <= `MRMC_GAIN_MAX)
        else $error("gain over range");
    a_bg_block: assert property (background_control_disable && !app_focus
        |=> !evt_valid && $stable(dim_ff))
        else $error("acted in background");
    a_main_vol: assert property (is_cc && ch0 && d1_ff == `MRMC_CC_VOLUME
        |=> main_vol_ff == $past(d2) && evt_kind == mrmc_ev_main_vol)
        else $error("main volume not set");
    a_standalone_row: assert property (standalone && row_ff != 2'd1 |=> row_ff != 2'd1)
        else $error("middle row entered");
    a_apb_answer: assert property (acc && !pready_ff |=> pready ##1 !pready)
        else $error("apb answer timing");
endmodule : mrmc_core

/* File: design/mrmc_defs.svh */
// Operation
// - channel 1 volume change sets main output
// - remote control always uses per-output mix view
// - channel 1 notes toggle dim, mono, talkback, speakers; recall note sends a recall event
// - notes 3E..42 pick cue source
// - notes 2D trim, 2C master mute, 2B solo
// - surface protocol off ignores note buttons
// - fader change is status, controller, value
// - channels map to top, middle, bottom rows
// - controllers 102..117 address sixteen faders per channel
// - channel nibble zero means channel one
// - value 68 unity, 7F max, 0 off
// - channel 13 controller 66 toggles trim gains
// - channel 13 controllers from 68 select mix
// - controller 9 sets input gain, capped 60
// - controller 0C picks reverb or echo preset
// - navigation buttons move block, record picks destination
// - display sends full or brief feedback
// - background disable stops control without focus
// - master fader drives main output
// - extender joins two remotes as one block
// - stand-alone skips middle row, brief display
`ifndef MRMC_DEFS_SVH
`define MRMC_DEFS_SVH
// ==========================================================
// register map
`define MRMC_ADDR_CTRL      8'h00
`define MRMC_ADDR_STATE     8'h04
`define MRMC_ADDR_MIX       8'h08
`define MRMC_ADDR_PRESET    8'h0c
`define MRMC_CTRL_RESET     7'h13
`define MRMC_BIT_REMOTE_EN  0
`define MRMC_BIT_SURFACE_EN 1
`define MRMC_BIT_FULL_DISP  2
`define MRMC_BIT_BG_DIS     3
`define MRMC_BIT_FOCUS      4
`define MRMC_BIT_EXTENDER   5
`define MRMC_BIT_STANDALONE 6
// ==========================================================
// message codes
`define MRMC_ST_NOTE_OFF    4'h8
`define MRMC_ST_NOTE_ON     4'h9
`define MRMC_ST_CTRL        4'hb
`define MRMC_ST_BEND        4'he
`define MRMC_CC_VOLUME      7'h07
`define MRMC_CC_GAIN        7'h09
`define MRMC_CC_PRESET      7'h0c
`define MRMC_CC_FADER_LO    7'h66
`define MRMC_CC_FADER_HI    7'h75
`define MRMC_CC_MIX_LO      7'h68
`define MRMC_CH_REVERB      4'h2
`define MRMC_CH_ECHO        4'h3
`define MRMC_CH_MASTER      4'h8
`define MRMC_CH_MIXSEL      4'hc
`define MRMC_CH_LAST_FADER  4'hb
`define MRMC_GAIN_MAX       7'h3c
`define MRMC_UNITY          7'h68
`define MRMC_PRESET_MAX     7'h10
// ==========================================================
// note buttons
`define MRMC_N_DIM          7'h5d
`define MRMC_N_MONO         7'h2a
`define MRMC_N_TALK         7'h5e
`define MRMC_N_RECALL       7'h5f
`define MRMC_N_SPKB         7'h32
`define MRMC_N_CUE_LO       7'h3e
`define MRMC_N_CUE_HI       7'h42
`define MRMC_N_SNAP_LO      7'h36
`define MRMC_N_SNAP_HI      7'h3d
`define MRMC_N_TRIM         7'h2d
`define MRMC_N_MMUTE        7'h2c
`define MRMC_N_MSOLO        7'h2b
`define MRMC_N_REC_LO       7'h00
`define MRMC_N_REC_HI       7'h07
`define MRMC_N_NAV_L1       7'h10
`define MRMC_N_NAV_R1       7'h11
`define MRMC_N_NAV_L8       7'h12
`define MRMC_N_NAV_R8       7'h13
`define MRMC_N_NAV_UP       7'h14
`define MRMC_N_NAV_DN       7'h15
`define MRMC_BLOCK_W        7'd8
`endif

/* File: design/mrmc_pkg.sv */
// ==========================================================
// shared types
package mrmc_pkg;
    typedef enum logic [3:0] {
        mrmc_ev_none,
        mrmc_ev_fader,
        mrmc_ev_main_vol,
        mrmc_ev_input_gain,
        mrmc_ev_reverb,
        mrmc_ev_echo,
        mrmc_ev_snapshot,
        mrmc_ev_recall
    } mrmc_event_t;
endpackage : mrmc_pkg

/* File: tb/mrmc_midi_src.sv */
`timescale 1ns/1ps
// ==========================================================
// midi source standing in for the control surface
module mrmc_midi_src (
    input  wire logic pclk,
    output logic      midi_valid,
    output logic [7:0] midi_byte
);
    // idle until a message is asked for
    initial begin
        midi_valid = 1'b0;
        midi_byte  = 8'h00;
    end
    // one message: status, note or controller, value
    task automatic send(input logic [7:0] st, input logic [7:0] d1, input logic [7:0] d2);
        logic [7:0] b [3];
        b = '{st, d1, d2};
        foreach (b[i]) begin
            @(posedge pclk);
            midi_valid <= 1'b1;
            midi_byte  <= b[i];
        end
        @(posedge pclk);
        midi_valid <= 1'b0;
        midi_byte  <= ~b[2]; // stale byte inverted, never reused
    endtask : send
endmodule : mrmc_midi_src

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`include "mrmc_defs.svh"
module tb_top
    import mrmc_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, midi_byte;
    logic [31:0] pwdata, prdata, rd;
    logic        midi_valid, evt_valid, disp_req, disp_full, er;
    mrmc_event_t evt_kind;
    logic [1:0]  evt_row, block_row;
    logic [5:0]  evt_index, block_col;
    logic [6:0]  evt_value;
    logic [18:0] q_exp[$], q_msk[$];
    int          n_errors, num_checks;
    // ==========================================================
    // clock and instances
    initial pclk = 1'b0;
    always #4 pclk = ~pclk;
    mrmc_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .midi_valid(midi_valid),
        .midi_byte(midi_byte), .evt_valid(evt_valid), .evt_kind(evt_kind),
        .evt_row(evt_row), .evt_index(evt_index), .evt_value(evt_value),
        .disp_req(disp_req), .disp_full(disp_full), .block_row(block_row),
        .block_col(block_col));
    mrmc_midi_src i_src (.pclk(pclk), .midi_valid(midi_valid), .midi_byte(midi_byte));
    // ==========================================================
    // tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task conclude;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    // apb transfer; pready sampled at a rising edge, released right after it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic note_evt(input mrmc_event_t k, input logic [1:0] r,
                            input logic [5:0] i, input logic [6:0] v, input logic [18:0] m);
        q_exp.push_back({k, r, i, v} & m);
        q_msk.push_back(m);
    endtask : note_evt
    task automatic fader(input logic [3:0] ch, input logic [6:0] cc, input logic [6:0] v);
        note_evt(mrmc_ev_fader, ch[3:2], {ch[1:0], 4'(cc - 7'h66)}, v, 19'h7ffff);
        i_src.send({4'hb, ch}, {1'b0, cc}, {1'b0, v});
    endtask : fader
    task automatic btn(input logic [7:0] st, input logic [7:0] n, input logic [7:0] vel);
        i_src.send(st, n, vel);
    endtask : btn
    // ==========================================================
    // monitor: oldest note against each event seen
    always @(negedge pclk) begin
        if (evt_valid === 1'b1) begin
            if (q_exp.size() == 0) chk(32'h1, 32'h0);
            else chk(32'({evt_kind, evt_row, evt_index, evt_value} & q_msk.pop_front()),
                     32'(q_exp.pop_front()));
        end
    end
    // watchdog, run needs well under 10k cycles
    initial begin
        #200000;
        n_errors++;
        conclude();
    end
    // ==========================================================
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        void'($urandom(79));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `MRMC_ADDR_CTRL, 0);
        chk(rd, 32'h13);
        apb(0, `MRMC_ADDR_MIX, 0);
        chk(32'(rd[29:23]), 32'h68);
        apb(0, 8'h40, 0);
        chk({er, rd[30:0]}, 32'h80000000);
        apb(1, `MRMC_ADDR_CTRL, 32'h17);
        repeat (2) @(posedge pclk);
        chk(32'(disp_full), 32'h1);
        $display("test registers done");
        fader(4'h0, 7'h66, 7'h68);
        fader(4'h1, 7'h66, 7'h00);
        fader(4'h4, 7'h66, 7'h7f);
        fader(4'h8, 7'h75, 7'h68);
        fader(4'h9, 7'h75, 7'h21);
        repeat (6) fader(4'($urandom % 12), 7'(7'h66 + $urandom % 16), 7'($urandom % 128));
        note_evt(mrmc_ev_main_vol, 2'd2, 6'd0, 7'h40, 19'h7e07f);
        i_src.send(8'hb0, 8'h07, 8'h40);
        note_evt(mrmc_ev_main_vol, 2'd2, 6'd0, 7'h55, 19'h7e07f);
        i_src.send(8'he8, 8'h00, 8'h55);
        note_evt(mrmc_ev_input_gain, 2'd0, 6'd3, 7'h3c, 19'h79fff);
        i_src.send(8'hb3, 8'h09, 8'h7f);
        note_evt(mrmc_ev_reverb, 2'd0, 6'd0, 7'h05, 19'h7807f);
        i_src.send(8'hb2, 8'h0c, 8'h05);
        note_evt(mrmc_ev_echo, 2'd0, 6'd0, 7'h10, 19'h7807f);
        i_src.send(8'hb3, 8'h0c, 8'h10);
        for (int k = 0; k < 8; k++) begin
            note_evt(mrmc_ev_snapshot, 2'd0, 6'(k), 7'h0, 19'h79f80);
            btn(8'h90, 8'(8'h36 + k), 8'h7f);
        end
        note_evt(mrmc_ev_recall, 2'd0, 6'd0, 7'h0, 19'h78000);
        btn(8'h90, 8'h5f, 8'h7f);
        $display("test events done");
        btn(8'h90, 8'h5d, 8'h7f);
        btn(8'h90, 8'h2a, 8'h7f);
        btn(8'h90, 8'h5e, 8'h7f);
        btn(8'h90, 8'h32, 8'h7f);
        btn(8'h90, 8'h2d, 8'h7f);
        btn(8'h90, 8'h2c, 8'h7f);
        btn(8'h90, 8'h2b, 8'h7f);
        btn(8'h90, 8'h5d, 8'h00);
        btn(8'h91, 8'h5d, 8'h7f);
        btn(8'h80, 8'h5d, 8'h40);
        apb(0, `MRMC_ADDR_STATE, 0);
        chk(rd & 32'h7f, 32'h7f);
        i_src.send(8'hbc, 8'h66, 8'h21);
        apb(1, `MRMC_ADDR_CTRL, 32'h15);
        btn(8'h90, 8'h2a, 8'h7f);
        apb(0, `MRMC_ADDR_STATE, 0);
        chk(rd & 32'h7f, 32'h6f);
        apb(1, `MRMC_ADDR_CTRL, 32'h17);
        btn(8'h90, 8'h40, 8'h7f);
        i_src.send(8'hbc, 8'h6a, 8'h00);
        apb(0, `MRMC_ADDR_MIX, 0);
        chk(32'({rd[14:12], rd[5:0]}), 32'({3'd2, 6'd2}));
        btn(8'h90, 8'h11, 8'h7f);
        @(posedge pclk);
        chk(32'(block_col), 32'h1);
        chk(32'(disp_req), 32'h1);
        // stand-alone with extender: middle row skipped, block is sixteen wide
        apb(1, `MRMC_ADDR_CTRL, 32'h77);
        i_src.send(8'hb5, 8'h66, 8'h10);
        btn(8'h90, 8'h15, 8'h7f);
        repeat (6) btn(8'h90, 8'h13, 8'h7f);
        @(posedge pclk);
        chk(32'(block_row), 32'h2);
        chk(32'(block_col), 32'd48);
        chk(32'(disp_full), 32'h0);
        i_src.send(8'hb0, 8'h01, 8'h33);
        apb(1, `MRMC_ADDR_CTRL, 32'h0f);
        i_src.send(8'hb0, 8'h66, 8'h10);
        repeat (4) @(posedge pclk);
        chk(32'(q_exp.size()), 32'h0);
        $display("test buttons done");
        conclude();
    end
endmodule : tb_top
